// ### rtl/ctl_word_regs.sv
/*
  combined timing strobe and dma support control word, with the strobe gating,
  the buffer byte swap path and the dma request pin logic.
  assumes event and status inputs come from logic on the same ram clock,
  while the host mode straps are pins and get synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
module ctl_word_regs
  import ctl_word_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  input wire logic [1:0] HOST_MODE_I,
  input wire ctl_word_pkg::timing_event_t EVENT_I,
  output ctl_word_pkg::timing_strobe_t STROBE_O,
  input wire logic [31:0] HOST_WDATA_I,
  output logic [31:0] IBUF_WDATA_O,
  input wire logic [31:0] BUF_RDATA_I,
  output logic [31:0] HOST_RDATA_O,
  input wire logic IBUF_FREE_I,
  input wire logic OBUF_READY_I,
  input wire logic DMA_SERVICED_I,
  output logic DMA_REQ_O,
  output logic DMA_REQ_OE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  timing_strobe_control_t strobe_ctl, next_strobe_ctl;
  dma_support_control_t dma_ctl, next_dma_ctl;
  logic [31:0] next_rdata;
  logic [1:0] mode_meta, mode_sync;
  logic hit;

  assign hit = (REG_ADDR_I == CTL_WORD_OFFSET);

  always_comb
  begin
    next_strobe_ctl = strobe_ctl;
    next_dma_ctl = dma_ctl;
    next_rdata = REG_RDATA_O;
    // only whole-word writes exist on this port, so no lane merging [R01]
    if (REG_WR_I && hit)
    begin
      next_strobe_ctl = timing_strobe_control_t'(REG_WDATA_I[31:STROBE_EN_BIT0]); // [R02]
      next_dma_ctl = dma_support_control_t'(REG_WDATA_I[SWAP_BIT:PIN_DRIVE_BIT]); // [R02]
    end
    if (REG_RD_I)
    begin
      // reserved bits are not stored and read as zero [R08]
      next_rdata = hit ? ({strobe_ctl, 23'h000000, dma_ctl} & CTL_WRITE_MASK) : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      strobe_ctl <= timing_strobe_control_t'(CTL_RESET[31:STROBE_EN_BIT0]);
      dma_ctl <= dma_support_control_t'(CTL_RESET[SWAP_BIT:PIN_DRIVE_BIT]);
      REG_RDATA_O <= 32'h0000_0000;
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end
    else
    begin
      strobe_ctl <= next_strobe_ctl;
      dma_ctl <= next_dma_ctl;
      REG_RDATA_O <= next_rdata;
      mode_meta <= HOST_MODE_I;
      mode_sync <= mode_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing strobes: one cycle high per event, low while disabled

  timing_strobe_t next_strobe;

  always_comb
  begin
    next_strobe.buf_update = EVENT_I.buf_update & {4{strobe_ctl.buf_update_strobe_en}}; // [R03]
    next_strobe.cycle_begin = EVENT_I.cycle_begin & strobe_ctl.cycle_begin_strobe_en; // [R04]
    next_strobe.tick = EVENT_I.tick & strobe_ctl.tick_strobe_en; // [R05]
    next_strobe.dyn_segment = EVENT_I.dyn_segment & strobe_ctl.dyn_segment_strobe_en; // [R06]
    next_strobe.cycle_zero = EVENT_I.cycle_zero & strobe_ctl.cycle_zero_strobe_en; // [R07]
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      STROBE_O <= '0;
    end
    else
    begin
      STROBE_O <= next_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte swap, one instance per direction
  // the halfword host mode splits words into two 16-bit beats upstream [R18]

  byte_lane_swap u_swap_wr
  (
    .CLOCK_I(CLOCK_I),
    .NRST_I(NRST_I),
    .swap_i(dma_ctl.byte_swap),
    .mode_i(host_mode_t'(mode_sync)),
    .data_i(HOST_WDATA_I),
    .data_o(IBUF_WDATA_O)
  );

  byte_lane_swap u_swap_rd
  (
    .CLOCK_I(CLOCK_I),
    .NRST_I(NRST_I),
    .swap_i(dma_ctl.byte_swap),
    .mode_i(host_mode_t'(mode_sync)),
    .data_i(BUF_RDATA_I),
    .data_o(HOST_RDATA_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // dma request; the pin is meant for the host dma request input [R17]

  logic req_pending, next_req_pending;
  logic next_pin, next_oe;

  always_comb
  begin
    next_req_pending = req_pending;
    // a fresh need wins over the service acknowledge
    if (DMA_SERVICED_I)
    begin
      next_req_pending = 1'b0; // [R19]
    end
    if (dma_ctl.dma_req_enable && (IBUF_FREE_I || OBUF_READY_I))
    begin
      next_req_pending = 1'b1; // [R14] [R19]
    end
    if (!dma_ctl.dma_req_enable)
    begin
      next_req_pending = 1'b0; // [R14]
    end
    next_oe = dma_ctl.dma_req_pin_drive; // [R16]
    // polarity and enable only reach the pin while it is driven [R15]
    next_pin = next_oe & (next_req_pending ^ dma_ctl.dma_req_polarity); // [R13] [R15]
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      req_pending <= 1'b0;
      DMA_REQ_O <= 1'b0;
      DMA_REQ_OE_O <= 1'b0;
    end
    else
    begin
      req_pending <= next_req_pending;
      DMA_REQ_O <= next_pin;
      DMA_REQ_OE_O <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_strobe_buf: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R03]
    STROBE_O.buf_update != 4'h0 |-> $past(strobe_ctl.buf_update_strobe_en))
    else $error("buffer update strobe while disabled");
  // the first edge after release still sees the enables of before reset
  a_strobe_cycle: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R04]
    $past(NRST_I) && $past(EVENT_I.cycle_begin && strobe_ctl.cycle_begin_strobe_en)
      |-> STROBE_O.cycle_begin)
    else $error("cycle start strobe missing");
  a_strobe_tick: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R05]
    STROBE_O.tick |-> $past(EVENT_I.tick) && $past(strobe_ctl.tick_strobe_en))
    else $error("macrotick strobe without cause");
  a_strobe_dyn: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R06]
    STROBE_O.dyn_segment |-> $past(EVENT_I.dyn_segment))
    else $error("dynamic segment strobe without event");
  a_strobe_zero: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R07]
    !$past(strobe_ctl.cycle_zero_strobe_en) |-> !STROBE_O.cycle_zero)
    else $error("cycle zero strobe while disabled");
  a_reserved_zero: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R08]
    (REG_RDATA_O & ~CTL_WRITE_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  a_write_lands: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R02]
    REG_WR_I && hit ##1 REG_RD_I && hit && !REG_WR_I
      |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & CTL_WRITE_MASK))
    else $error("written word not read back");
  a_pin_hiz: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R16]
    !DMA_REQ_OE_O |-> !DMA_REQ_O)
    else $error("dma pin value while not driven");
  a_pin_drive: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R16]
    $past(NRST_I) |-> DMA_REQ_OE_O == $past(dma_ctl.dma_req_pin_drive))
    else $error("dma pin enable does not follow control bit");
  a_req_level: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R13] [R14]
    DMA_REQ_OE_O && !$past(dma_ctl.dma_req_enable) && !$past(req_pending)
      |-> DMA_REQ_O == $past(dma_ctl.dma_req_polarity))
    else $error("idle dma level wrong");
  a_req_disabled: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R14]
    !$past(dma_ctl.dma_req_enable) |-> !req_pending)
    else $error("dma request pending while disabled");
  a_swap_off: assert property (@(posedge CLOCK_I) disable iff (!NRST_I) // [R09]
    $past(NRST_I) && !$past(dma_ctl.byte_swap) |-> IBUF_WDATA_O == $past(HOST_WDATA_I))
    else $error("buffer data altered with swap off");

  c_cycle_strobe: cover property (@(posedge CLOCK_I) STROBE_O.cycle_begin);
  c_dma_active: cover property (@(posedge CLOCK_I) DMA_REQ_OE_O && req_pending);
  c_swap_half: cover property (@(posedge CLOCK_I)
    dma_ctl.byte_swap && mode_sync == 2'h2);

endmodule : ctl_word_regs
`default_nettype wire

// ### shared/ctl_word_pkg.sv
/*
  constants and carrier types of the combined strobe and dma control word.
  assumes a single 200 mhz clock domain (the internal ram clock) and a 32-bit
  register access port inside the device.
*/
// Notes on behaviour
// R01: host writes word at 0x0008, full 32 bits
// R02: upper half strobes, lower half dma controls
// R03: bit31 gates one-cycle buffer update strobes
// R04: bit30 gates one-cycle cycle start strobe
// R05: bit29 gates one-cycle macrotick strobe
// R06: bit28 gates one-cycle dynamic segment strobe
// R07: bit27 gates one-cycle cycle zero strobe
// R08: reserved bits read zero, host writes zero
// R09: swap clear passes buffer data unchanged
// R10: edge modes with swap reverse all bytes
// R11: halfword mode swaps bytes inside halves
// R12: swap ignored in serial host mode
// R13: bit2 selects dma request active level
// R14: bit1 enables dma request generation
// R15: polarity and enable matter only when driven
// R16: bit0 clear tri-states dma request pin
// R17: host wires dma request to its dma
// R18: parallel host uses two 16-bit accesses
// R19: request when input free or output ready
package ctl_word_pkg;

  localparam logic [15:0] CTL_WORD_OFFSET = 16'h0008;
  localparam int STROBE_EN_BIT0 = 27;
  localparam int SWAP_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int REQ_EN_BIT = 1;
  localparam int PIN_DRIVE_BIT = 0;
  localparam logic [31:0] CTL_WRITE_MASK = 32'hf800_000f;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam int SYNC_STAGES = 2;

  // host bus modes as picked by the mode straps
  typedef enum logic [1:0]
  {
    MODE_RISE_EDGE,
    MODE_FALL_EDGE,
    MODE_HALFWORD_SWAP,
    MODE_SERIAL
  } host_mode_t;

  typedef struct packed
  {
    logic buf_update_strobe_en;
    logic cycle_begin_strobe_en;
    logic tick_strobe_en;
    logic dyn_segment_strobe_en;
    logic cycle_zero_strobe_en;
  } timing_strobe_control_t;

  typedef struct packed
  {
    logic byte_swap;
    logic dma_req_polarity;
    logic dma_req_enable;
    logic dma_req_pin_drive;
  } dma_support_control_t;

  // protocol timing events, one cycle pulses from the engine
  typedef struct packed
  {
    logic [3:0] buf_update;
    logic cycle_begin;
    logic tick;
    logic dyn_segment;
    logic cycle_zero;
  } timing_event_t;

  typedef struct packed
  {
    logic [3:0] buf_update;
    logic cycle_begin;
    logic tick;
    logic dyn_segment;
    logic cycle_zero;
  } timing_strobe_t;

endpackage : ctl_word_pkg

// ### rtl/byte_lane_swap.sv
/*
  byte lane reorder for buffer data between host and buffers.
  assumes a registered path is acceptable: output follows input one clock later.
*/
`timescale 1ns/100ps
`default_nettype none
module byte_lane_swap
  import ctl_word_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic swap_i,
  input wire host_mode_t mode_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o
);

  logic [31:0] next_data;

  always_comb
  begin
    next_data = data_i; // [R09]
    if (swap_i)
    begin
      unique case (mode_i)
        MODE_RISE_EDGE, MODE_FALL_EDGE:
        begin
          next_data = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]}; // [R10]
        end
        MODE_HALFWORD_SWAP:
        begin
          next_data = {data_i[23:16], data_i[31:24], data_i[7:0], data_i[15:8]}; // [R11]
        end
        MODE_SERIAL:
        begin
          next_data = data_i; // [R12]
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      data_o <= 32'h0000_0000;
    end
    else
    begin
      data_o <= next_data;
    end
  end

endmodule : byte_lane_swap
`default_nettype wire

// ### verification/dma_host_model.sv
/*
  host dma controller model: answers the dma request pin after a set delay.
  assumes the pin and its enable come straight from the device, same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_host_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic oe_i,
  input wire logic active_low_i,
  input wire logic [3:0] delay_i,
  output logic serviced_o
);
  logic [3:0] cnt;
  // a pin that is not driven is never taken for a request
  always @(posedge clk_i)
  begin
    serviced_o <= 1'b0;
    cnt <= 4'h0;
    if (nrst_i && oe_i && (req_i ^ active_low_i) && !serviced_o)
    begin
      if (cnt >= delay_i)
        serviced_o <= 1'b1;
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule : dma_host_model
`default_nettype wire

// ### verification/debug_strobe_dma_support_reg_tb.sv
/*
  self-checking bench for the control word, strobes, swap path and dma pin.
  assumes the host model answers the request and the bench plays the engine.
*/
`timescale 1ns/100ps
`default_nettype none
module debug_strobe_dma_support_reg_tb
  import ctl_word_pkg::*;
;
  typedef struct packed {logic [1:0] mode; logic swap; logic [31:0] exp;} row_t;
  logic clk, nrst, wr_s, rd_s, free, rdy, svc, req, oe, act_low;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, hw, iw, br, hr;
  logic [1:0] mode;
  logic [3:0] dly;
  timing_event_t ev;
  timing_strobe_t strb;
  int fails = 0;
  int tests_run = 0;
  logic [7:0] smask [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hf0};
  row_t rows [8] = '{'{2'h0, 1'b0, 32'h11223344}, '{2'h0, 1'b1, 32'h44332211},
    '{2'h1, 1'b0, 32'h11223344}, '{2'h1, 1'b1, 32'h44332211},
    '{2'h2, 1'b0, 32'h11223344}, '{2'h2, 1'b1, 32'h22114433},
    '{2'h3, 1'b0, 32'h11223344}, '{2'h3, 1'b1, 32'h11223344}};

  ctl_word_regs ctl_word_regs_i (.CLOCK_I(clk), .NRST_I(nrst), .REG_WR_I(wr_s),
    .REG_RD_I(rd_s), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .HOST_MODE_I(mode), .EVENT_I(ev), .STROBE_O(strb), .HOST_WDATA_I(hw),
    .IBUF_WDATA_O(iw), .BUF_RDATA_I(br), .HOST_RDATA_O(hr), .IBUF_FREE_I(free),
    .OBUF_READY_I(rdy), .DMA_SERVICED_I(svc), .DMA_REQ_O(req), .DMA_REQ_OE_O(oe));
  dma_host_model dma_host_model_i (.clk_i(clk), .nrst_i(nrst), .req_i(req),
    .oe_i(oe), .active_low_i(act_low), .delay_i(dly), .serviced_o(svc));

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // whole 32-bit word per access, never split into 16-bit halves
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    cyc(1);
    wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    addr = a;
    rd_s = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    cyc(1);
    check(rdata, exp);
  endtask : rd
  task automatic wait_req(input logic v);
    int i;
    i = 0;
    while (req !== v && i < 20)
    begin
      cyc(1);
      i++;
    end
    check(32'(req), 32'(v));
    if (i == 20)
      give_verdict();
  endtask : wait_req
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {nrst, wr_s, rd_s, free, rdy, act_low, addr, wdata, hw, br, mode, dly, ev} = '0;
    cyc(5);
    check({oe, req, 22'h0, strb}, 32'h0);
    nrst = 1'b1;
    cyc(2);
    rd(16'h0008, 32'h0);
    wr(16'h0008, 32'hffff_ffff);
    rd(16'h0008, 32'hf800_000f);
    rd(16'h000c, 32'h0);
    // mode straps go through a synchroniser, so settle before the data
    foreach (rows[r])
    begin
      mode = rows[r].mode;
      wr(16'h0008, {28'h0, rows[r].swap, 3'h0});
      cyc(3);
      hw = 32'h11223344;
      br = 32'h11223344;
      cyc(1);
      check(iw, rows[r].exp);
      check(hr, rows[r].exp);
    end
    for (int k = 0; k < 6; k++)
    begin
      wr(16'h0008, k < 5 ? 32'h0800_0000 << k : 32'h0);
      ev = 8'hff;
      cyc(1);
      ev = 8'h00;
      check({24'h0, strb}, k < 5 ? {24'h0, smask[k]} : 32'h0);
      cyc(1);
      check({24'h0, strb}, 32'h0);
    end
    wr(16'h0008, 32'h3);
    cyc(2);
    check({30'h0, oe, req}, 32'h2);
    pulse(free);
    wait_req(1'b1);
    wait_req(1'b0);
    act_low = 1'b1;
    dly = 4'h3;
    wr(16'h0008, 32'h7);
    cyc(2);
    check(32'(req), 32'h1);
    pulse(rdy);
    wait_req(1'b0);
    wait_req(1'b1);
    wr(16'h0008, 32'h5);
    pulse(rdy);
    cyc(3);
    check(32'(req), 32'h1);
    wr(16'h0008, 32'h6);
    pulse(rdy);
    cyc(3);
    check({30'h0, oe, req}, 32'h0);
    // reset in mid-run must clear the word and park the strobes, dma pin and read data
    nrst = 1'b0;
    cyc(2);
    check({oe, req, 22'h0, strb}, 32'h0);
    check(rdata, 32'h0);
    nrst = 1'b1;
    cyc(2);
    rd(16'h0008, 32'h0);
    check({30'h0, oe, req}, 32'h0);
    give_verdict();
  end
endmodule : debug_strobe_dma_support_reg_tb
`default_nettype wire
